// file: logic/iostp_pkg.sv
// constants shared by the interrupted operation stepper
package iostp_pkg;
    // apb register byte offsets
    localparam logic [7:0] CtrlOff = 8'h00;
    localparam logic [7:0] StatusOff = 8'h04;
    localparam logic [7:0] IntStatOff = 8'h08;
    localparam logic [7:0] IntMaskOff = 8'h0c;

    // control register fields
    localparam int CtrlModeLsb = 0;
    localparam int CtrlModeW = 3;
    localparam int CtrlOverrideBit = 3;
    localparam int CtrlRetainBit = 4;
    localparam logic [4:0] CtrlReset = 5'h00;

    // status register fields
    localparam int StatStopBit = 0;
    localparam int StatToABit = 1;
    localparam int StatToBBit = 2;
    localparam int StatErrPendBit = 3;
    localparam int StatModeLsb = 4;

    // interrupt bits, same layout in status and mask
    localparam int IntW = 3;
    localparam int IntHaltBit = 0;
    localparam int IntCmpErrBit = 1;
    localparam int IntErrBit = 2;
    localparam logic [IntW-1:0] IntMaskReset = 3'h0;

    // number of duplicated time-out flip-flops
    localparam int DupCount = 2;

    // segment size chosen by the selector
    typedef enum logic [2:0] {
        ModeContinuous = 3'b000,
        ModeStep = 3'b001,
        ModeAddition = 3'b010,
        ModeOperation = 3'b011,
        ModeInstruction = 3'b100
    } iostp_mode_t;
endpackage

// file: logic/iostp_timeout_ff.sv
// one copy of the duplicated time-out flip-flop
`timescale 1ns/1ns
module iostp_timeout_ff (
    input wire logic clk,
    input wire logic rstN,
    input wire logic setPulse,
    input wire logic restorePulse,
    input wire logic restoreBlock,
    output logic timeOut
);
    logic timeOut_q;
    logic timeOut_d;

    // set wins over a restore in the same cycle
    always_comb begin
        timeOut_d = timeOut_q;
        if (restorePulse && !restoreBlock) begin
            timeOut_d = 1'b0;
        end
        if (setPulse) begin
            timeOut_d = 1'b1;
        end
    end

    always_ff @(posedge clk or negedge rstN) begin
        if (!rstN) begin
            timeOut_q <= 1'b1;
        end else begin
            timeOut_q <= timeOut_d;
        end
    end

    assign timeOut = timeOut_q;
endmodule

// file: logic/iostp_stepper.sv
// interrupted operation stepper with apb registers and interrupt
//
// Our own choices: the placing of the registers and the APB interface to the registers.
`timescale 1ns/1ns
// Notes on behaviour
// - segment done sets stop, blocks time-out restore
// - step mode halts on each counter step
// - addition mode halts after each minor cycle
// - operation mode halts on time-out, after all words
// - start bar runs one more segment
// - center position runs with no segment halts
// - instruction mode halts in time out
// - duplicate time-out flip-flops, flag divergence
// - error halts at next time out
// - override keeps errors from halting
// - retained instruction repeats in continuous mode
module iostp_stepper (
    input wire logic core_clk,
    input wire logic arst_n,
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [7:0] paddr,
    input wire logic [31:0] pwdata,
    output logic [31:0] prdata,
    output logic pready,
    output logic pslverr,
    input wire logic pcStep,
    input wire logic minorCycleDone,
    input wire logic timeOutSet,
    input wire logic timeOutRestore,
    input wire logic multiwordBusy,
    input wire logic errorDetected,
    input wire logic startBar,
    output logic haltReq,
    output logic timeOutA,
    output logic timeOutB,
    output logic compareError,
    output logic reloadStatic,
    output logic irq
);
    logic [1:0] rstSync_q;
    logic rstN;

    localparam int IntWidth = iostp_pkg::IntW;

    logic [4:0] ctrl_q;
    logic [IntWidth-1:0] intStat_q;
    logic [IntWidth-1:0] intStat_d;
    logic [IntWidth-1:0] intMask_q;
    logic [31:0] prdata_q;
    logic pready_q;
    logic pslverr_q;
    logic irq_q;

    iostp_pkg::iostp_mode_t modeSync_q;
    logic stop_q;
    logic stop_d;
    logic errPend_q;
    logic errPend_d;
    logic cmpErr_q;
    logic reload_q;
    logic [iostp_pkg::DupCount-1:0] dupTimeOut;

    // reset release through two flops
    always_ff @(posedge core_clk or negedge arst_n) begin
        if (!arst_n) begin
            rstSync_q <= 2'h0;
        end else begin
            rstSync_q <= {rstSync_q[0], 1'b1};
        end
    end
    assign rstN = rstSync_q[1];

    // ---- apb decode ----
    wire setupPhase = psel && !penable;
    wire writeTaken = psel && penable && pready_q && pwrite;
    wire hitCtrl = paddr == iostp_pkg::CtrlOff;
    wire hitStatus = paddr == iostp_pkg::StatusOff;
    wire hitIntStat = paddr == iostp_pkg::IntStatOff;
    wire hitIntMask = paddr == iostp_pkg::IntMaskOff;
    wire hitAny = hitCtrl || hitStatus || hitIntStat || hitIntMask;
    wire wrCtrl = writeTaken && hitCtrl;
    wire wrIntStat = writeTaken && hitIntStat;
    wire wrIntMask = writeTaken && hitIntMask;

    wire [31:0] statusWord = {
        25'h0000000,
        modeSync_q,
        errPend_q,
        dupTimeOut[1],
        dupTimeOut[0],
        stop_q
    };

    wire [31:0] readMux =
        hitCtrl ? {27'h0000000, ctrl_q} :
        hitStatus ? statusWord :
        hitIntStat ? {29'h00000000, intStat_q} :
        hitIntMask ? {29'h00000000, intMask_q} :
        32'h00000000;

    // answer is ready in the first access cycle; status read is a
    // snapshot from the setup cycle, one cycle old at completion
    always_ff @(posedge core_clk or negedge rstN) begin
        if (!rstN) begin
            pready_q <= 1'b0;
            prdata_q <= 32'h00000000;
            pslverr_q <= 1'b0;
        end else begin
            pready_q <= setupPhase;
            if (setupPhase) begin
                prdata_q <= pwrite ? 32'h00000000 : readMux;
                pslverr_q <= !hitAny;
            end
        end
    end

    always_ff @(posedge core_clk or negedge rstN) begin
        if (!rstN) begin
            ctrl_q <= iostp_pkg::CtrlReset;
            intMask_q <= iostp_pkg::IntMaskReset;
        end else begin
            if (wrCtrl) begin
                ctrl_q <= pwdata[4:0];
            end
            if (wrIntMask) begin
                intMask_q <= pwdata[IntWidth-1:0];
            end
        end
    end

    wire [2:0] ctrlMode =
        ctrl_q[iostp_pkg::CtrlModeLsb +: iostp_pkg::CtrlModeW];
    wire overrideOn = ctrl_q[iostp_pkg::CtrlOverrideBit];
    wire retainOn = ctrl_q[iostp_pkg::CtrlRetainBit];

    // selector resampled only while in time out
    // a selector change mid-instruction cannot reach one copy of the
    // time-out logic before the other; it waits for the next time out
    wire bothInTimeOut = &dupTimeOut;
    always_ff @(posedge core_clk or negedge rstN) begin
        if (!rstN) begin
            modeSync_q <= iostp_pkg::ModeContinuous;
        end else if (bothInTimeOut && !timeOutRestore) begin
            unique case (ctrlMode)
                3'b001: modeSync_q <= iostp_pkg::ModeStep;
                3'b010: modeSync_q <= iostp_pkg::ModeAddition;
                3'b011: modeSync_q <= iostp_pkg::ModeOperation;
                3'b100: modeSync_q <= iostp_pkg::ModeInstruction;
                default: modeSync_q <= iostp_pkg::ModeContinuous;
            endcase
        end
    end

    // ---- segment end detection ----
    logic segmentDone;
    always_comb begin
        segmentDone = 1'b0;
        unique case (modeSync_q)
            iostp_pkg::ModeStep: segmentDone = pcStep;
            iostp_pkg::ModeAddition: segmentDone = minorCycleDone;
            iostp_pkg::ModeOperation: segmentDone = timeOutSet &&
                !multiwordBusy;
            iostp_pkg::ModeInstruction: segmentDone = timeOutSet;
            iostp_pkg::ModeContinuous: segmentDone = 1'b0;
            default: segmentDone = 1'b0;
        endcase
    end

    // error waits for the next time out
    wire errorStop = (errPend_q || errorDetected) && timeOutSet &&
        !overrideOn;

    always_comb begin
        errPend_d = errPend_q;
        if (startBar) begin
            errPend_d = 1'b0;
        end
        if (errorDetected && !overrideOn) begin
            errPend_d = 1'b1;
        end
        if (overrideOn) begin
            errPend_d = 1'b0;
        end
    end

    // start bar releases stop for one segment
    always_comb begin
        stop_d = stop_q;
        if (startBar) begin
            stop_d = 1'b0;
        end
        if (segmentDone || errorStop) begin
            stop_d = 1'b1;
        end
    end

    always_ff @(posedge core_clk or negedge rstN) begin
        if (!rstN) begin
            stop_q <= 1'b1;
            errPend_q <= 1'b0;
        end else begin
            stop_q <= stop_d;
            errPend_q <= errPend_d;
        end
    end

    // stop blocks the restoring input of every copy
    genvar gi;
    generate
        for (gi = 0; gi < iostp_pkg::DupCount; gi++) begin : gDup
            iostp_timeout_ff uTimeOut (
                .clk(core_clk),
                .rstN(rstN),
                .setPulse(timeOutSet),
                .restorePulse(timeOutRestore),
                .restoreBlock(stop_q),
                .timeOut(dupTimeOut[gi])
            );
        end
    endgenerate

    // copies that disagree flag a comparison error
    wire dupMismatch = dupTimeOut[0] != dupTimeOut[1];

    // repeat the retained instruction on each restore in continuous mode
    wire restoreTaken = timeOutRestore && !stop_q && bothInTimeOut;
    wire reloadNow = restoreTaken && retainOn &&
        modeSync_q == iostp_pkg::ModeContinuous;

    always_ff @(posedge core_clk or negedge rstN) begin
        if (!rstN) begin
            cmpErr_q <= 1'b0;
            reload_q <= 1'b0;
        end else begin
            cmpErr_q <= dupMismatch;
            reload_q <= reloadNow;
        end
    end

    // ---- interrupt status, write one to clear, set wins ----
    wire haltEvent = stop_d && !stop_q;
    wire [IntWidth-1:0] intEvents = {errorDetected, dupMismatch, haltEvent};
    wire [IntWidth-1:0] intClear =
        wrIntStat ? pwdata[IntWidth-1:0] : {IntWidth{1'b0}};

    always_comb begin
        intStat_d = (intStat_q & ~intClear) | intEvents;
    end

    always_ff @(posedge core_clk or negedge rstN) begin
        if (!rstN) begin
            intStat_q <= {IntWidth{1'b0}};
            irq_q <= 1'b0;
        end else begin
            intStat_q <= intStat_d;
            irq_q <= |(intStat_d & intMask_q);
        end
    end

    assign prdata = prdata_q;
    assign pready = pready_q;
    assign pslverr = pslverr_q;
    assign haltReq = stop_q;
    assign timeOutA = dupTimeOut[0];
    assign timeOutB = dupTimeOut[1];
    assign compareError = cmpErr_q;
    assign reloadStatic = reload_q;
    assign irq = irq_q;
endmodule

// file: sim/iostp_stepper_assertions.sv
// port assertions for the interrupted operation stepper
`timescale 1ns/1ns
module iostp_stepper_chk (
    input wire logic core_clk,
    input wire logic arst_n,
    input wire logic pcStep,
    input wire logic minorCycleDone,
    input wire logic timeOutSet,
    input wire logic timeOutRestore,
    input wire logic errorDetected,
    input wire logic startBar,
    input wire logic haltReq,
    input wire logic timeOutA,
    input wire logic timeOutB,
    input wire logic compareError,
    input wire logic reloadStatic
);
    default clocking cb @(posedge core_clk); endclocking
    default disable iff (!arst_n);
    wire cause = pcStep || minorCycleDone || timeOutSet;
    sequence s_halted;
        haltReq && timeOutA;
    endsequence
    sequence s_held;
        timeOutA && timeOutB;
    endsequence
    a_restore_blocked: assert property (s_halted and timeOutRestore |=> s_held)
        else $error("restore taken while halted");
    a_halt_holds: assert property (haltReq && !startBar |=> haltReq)
        else $error("halt dropped without start bar");
    a_halt_cause: assert property ($rose(haltReq) |-> $past(cause))
        else $error("halt rose without a segment end");
    a_start_clears: assert property (haltReq && startBar && !cause |=> !haltReq)
        else $error("start bar did not release halt");
    a_twins_agree: assert property (timeOutA == timeOutB)
        else $error("time-out copies differ");
    a_cmp_flag: assert property (compareError == $past(timeOutA != timeOutB))
        else $error("compare flag wrong");
    a_error_defer: assert property (errorDetected && !haltReq && !cause |=> !haltReq)
        else $error("error halted outside time out");
    a_reload_cause: assert property (reloadStatic |-> $past(timeOutRestore))
        else $error("reload without restore");
endmodule

// file: sim/iostp_machine_model.sv
// machine and technician pulse source facing the stepper
`timescale 1ns/1ns
module iostp_machine_model (
    input wire logic clk,
    output logic pcStep,
    output logic minorCycleDone,
    output logic timeOutSet,
    output logic timeOutRestore,
    output logic errorDetected,
    output logic startBar,
    output logic multiwordBusy
);
    logic [5:0] p = 6'h00;
    initial multiwordBusy = 1'b0;
    assign {startBar, errorDetected, timeOutRestore} = p[5:3];
    assign {timeOutSet, minorCycleDone, pcStep} = p[2:0];
    task automatic fire(input int k);
        @(posedge clk);
        p[k] <= 1'b1;
        @(posedge clk);
        p[k] <= 1'b0;
        #1;
    endtask
    task automatic busy(input logic v);
        @(posedge clk);
        multiwordBusy <= v;
    endtask
endmodule

// file: sim/interrupted_operation_stepper_bench.sv
// self-checking bench for the interrupted operation stepper
`timescale 1ns/1ns
module interrupted_operation_stepper_bench;
    logic core_clk = 1'b0, arst_n = 1'b0, psel = 1'b0, penable = 1'b0;
    logic pwrite = 1'b0, re;
    logic [7:0] paddr = 8'h00;
    logic [31:0] pwdata = 32'h0, prdata, rd, m;
    logic pready, pslverr, pcStep, minorCycleDone, timeOutSet, startBar;
    logic timeOutRestore, multiwordBusy, errorDetected, reloadStatic;
    logic haltReq, timeOutA, timeOutB, compareError, irq;
    int nFail = 0, checksDone = 0;
    int cause[4] = '{0, 1, 2, 2};
    int wrong[4] = '{1, 0, 0, 1};
    initial forever #5 core_clk = ~core_clk;
    iostp_stepper i_iostp_stepper (.*);
    iostp_machine_model i_iostp_machine_model (.clk(core_clk), .*);
    task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
        checksDone++;
        if (seen !== exp) begin
            nFail++;
            $display("mismatch at %0t: got %h want %h", $time, seen, exp);
        end
    endtask
    task automatic giveVerdict();
        $display("checks %0d mismatches %0d", checksDone, nFail);
        if (nFail == 0 && checksDone > 0)
            $display("[ PASS ]");
        else
            $display("[ FAIL ]");
        $finish;
    endtask
    task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
        int n;
        @(posedge core_clk);
        psel <= 1'b1;
        pwrite <= w;
        paddr <= a;
        pwdata <= d;
        @(posedge core_clk);
        penable <= 1'b1;
        n = 0;
        // look at pready where it has settled, before the edge samples it
        @(negedge core_clk);
        while (pready !== 1'b1 && n < 16) begin
            @(negedge core_clk);
            n++;
        end
        if (pready !== 1'b1) begin
            chk(32'h0, 32'h1);
            giveVerdict();
        end
        rd = prdata;
        re = pslverr;
        @(posedge core_clk);
        psel <= 1'b0;
        penable <= 1'b0;
        #1;
    endtask
    task automatic rdc(input logic [7:0] a, input logic [31:0] e);
        apb(1'b0, a, 32'h0);
        chk(rd, e);
    endtask
    // status word and the halt and time-out pins agree
    task automatic st(input logic [31:0] e);
        rdc(iostp_pkg::StatusOff, e);
        chk(32'({timeOutB, timeOutA, haltReq}), e & 32'h7);
        chk(32'(compareError), 32'h0);
    endtask
    task automatic f(input int k);
        i_iostp_machine_model.fire(k);
    endtask
    task automatic hc(input logic e);
        chk(32'(haltReq), 32'(e));
    endtask
    initial begin
        repeat (16) @(posedge core_clk);
        arst_n <= 1'b1;
        repeat (3) @(posedge core_clk);
        st(32'h07);
        rdc(iostp_pkg::CtrlOff, 32'h0);
        apb(1'b0, 8'h10, 32'h0);
        chk({rd[30:0], re}, 32'h1);
        apb(1'b1, iostp_pkg::IntMaskOff, 32'h7);
        f(5);
        f(3);
        f(2);
        st(32'h06);
        for (int i = 0; i < 4; i++) begin
            m = 32'(i + 1);
            apb(1'b1, iostp_pkg::CtrlOff, m);
            f(5);
            st(32'h06 | m << 4);
            f(3);
            f(wrong[i]);
            st(m << 4);
            if (i == 2) begin
                i_iostp_machine_model.busy(1'b1);
                f(2);
                hc(1'b0);
                f(3);
                i_iostp_machine_model.busy(1'b0);
            end
            f(cause[i]);
            hc(1'b1);
            f(2);
            f(3);
            st(32'h07 | m << 4);
            f(5);
            hc(1'b0);
            f(cause[i]);
            hc(1'b1);
        end
        chk(32'(irq), 32'h1);
        apb(1'b1, iostp_pkg::IntStatOff, 32'h1);
        rdc(iostp_pkg::IntStatOff, 32'h0);
        chk(32'(irq), 32'h0);
        apb(1'b1, iostp_pkg::CtrlOff, 32'h0);
        f(5);
        f(3);
        f(4);
        st(32'h08);
        f(2);
        hc(1'b1);
        rdc(iostp_pkg::IntStatOff, 32'h5);
        apb(1'b1, iostp_pkg::IntStatOff, 32'h7);
        apb(1'b1, iostp_pkg::IntMaskOff, 32'h3);
        apb(1'b1, iostp_pkg::CtrlOff, 32'h8);
        f(5);
        f(3);
        f(4);
        f(2);
        hc(1'b0);
        rdc(iostp_pkg::IntStatOff, 32'h4);
        chk(32'(irq), 32'h0);
        apb(1'b1, iostp_pkg::CtrlOff, 32'h10);
        f(3);
        chk(32'(reloadStatic), 32'h1);
        f(2);
        f(3);
        chk(32'(reloadStatic), 32'h1);
        hc(1'b0);
        giveVerdict();
    end
endmodule
bind iostp_stepper iostp_stepper_chk i_iostp_stepper_chk (.*);
